// file: hdl/psq_consts.vh
// constants for the program sequencer, stack and vectors
`ifndef PSQ_CONSTS_VH
`define PSQ_CONSTS_VH
// ****************************************
// register byte offsets
// ****************************************
`define PSQ_OFF_PCL 12'h000
`define PSQ_OFF_TBLP 12'h004
`define PSQ_OFF_TABLE_HIGH_BYTE 12'h008
`define PSQ_OFF_INTEN 12'h00c
`define PSQ_OFF_STAT 12'h010
// ****************************************
// interrupt enable, pending and status bit positions
// ****************************************
`define PSQ_IRQ_EXT 0
`define PSQ_IRQ_TM0 1
`define PSQ_IRQ_TM1 2
`define PSQ_IRQ_RTC 3
`define PSQ_IRQ_MFI 4
`define PSQ_EN_RTCFN 5
`define PSQ_STAT_DUMMY 8
`define PSQ_STAT_TAB 9
// ****************************************
// vectors and reset values
// ****************************************
`define PSQ_VEC_RESET 12'h000
`define PSQ_VEC_EXT 12'h004
`define PSQ_VEC_TM0 12'h008
`define PSQ_VEC_TM1 12'h00c
`define PSQ_VEC_RTC 12'h014
`define PSQ_VEC_MFI 12'h018
`define PSQ_LAST_PAGE 4'hf
`define PSQ_RST_TBLP 8'h00
`define PSQ_RST_INTEN 6'h00
// ****************************************
// timing, in instruction cycles
// ****************************************
`define PSQ_BRANCH_CYC 2
`define PSQ_TABRD_CYC 2
`endif

// file: hdl/psq_sequencer.v
// program counter, return stack, interrupt vectors and table read path
//
// The implementer's own choices: the placing of the registers and the APB slave port.
`timescale 1ns/1ps
`include "psq_consts.vh"
module psq_sequencer #(
  parameter PC_W = 12,
  parameter STACK_DEPTH = 8
) (
  // clock and reset
  input wire pclk,
  input wire presetn,
  // apb slave
  input wire psel,
  input wire penable,
  input wire pwrite,
  input wire [11:0] paddr,
  input wire [31:0] pwdata,
  output reg [31:0] prdata,
  output wire pready,
  output wire pslverr,
  // decoded instruction from the core
  input wire instr_valid,
  input wire op_skip,
  input wire op_jump,
  input wire op_call,
  input wire op_sub_ret,
  input wire op_int_ret,
  input wire op_tab_cur,
  input wire op_tab_last,
  input wire [PC_W-1:0] jump_target,
  input wire [7:0] tab_dest,
  // program memory port
  output wire [PC_W-1:0] pm_addr,
  input wire [15:0] pm_rdata,
  // interrupt sources
  input wire ext_int_n,
  input wire tmr0_ovf,
  input wire tmr1_ovf,
  input wire rtc_timeout,
  input wire port_c_bit0,
  input wire port_c_bit5,
  input wire port_c_bit7,
  // status towards the core
  output wire [PC_W-1:0] pc,
  output wire core_stall,
  output wire dummy_cycle,
  output reg int_ack,
  output reg [PC_W-1:0] int_vector,
  output reg tab_wr,
  output reg [7:0] tab_low,
  output reg [7:0] tab_dest_out,
  output wire [7:0] table_high_byte
);
  // ****************************************
  // states
  // ****************************************
  localparam [1:0] ST_RUN = 2'd0;
  localparam [1:0] ST_DUMMY = 2'd1;
  localparam [1:0] ST_TAB = 2'd2;
  localparam SP_W = 3;

  // next sequential address, wrapping in the 4k space
  function [PC_W-1:0] psq_add;
    input [PC_W-1:0] a;
    input [PC_W-1:0] b;
    begin
      psq_add = a + b;
    end
  endfunction

  reg [1:0] state_q;
  reg [1:0] state_d;
  reg [PC_W-1:0] pc_q;
  reg [PC_W-1:0] pc_d;
  reg [PC_W-1:0] stack_mem [0:STACK_DEPTH-1];
  reg [SP_W-1:0] stack_index_q;
  reg [SP_W-1:0] stack_index_d;
  reg [SP_W:0] depth_q;
  reg [SP_W:0] depth_d;
  reg push;
  reg [PC_W-1:0] push_val;
  reg [7:0] tblp_q;
  reg [7:0] table_high_byte_q;
  reg [PC_W-1:0] tab_addr_q;
  reg [7:0] tab_dest_q;
  reg [5:0] inten_q;
  reg [4:0] pend_q;
  reg [4:0] pend_d;
  reg [4:0] ack_mask;
  reg ext_prev_q;
  reg pc0_prev_q;
  reg pc5_prev_q;
  reg pc7_prev_q;
  wire stack_full;
  wire [4:0] events;
  wire [4:0] active;
  wire int_take;
  wire accept;
  wire apb_wr;
  wire pcl_wr;

  // ****************************************
  // apb access decode
  // ****************************************
  assign pready = 1'b1;
  assign apb_wr = psel & penable & pwrite;
  assign pcl_wr = apb_wr & (paddr == `PSQ_OFF_PCL);
  assign pslverr = psel & penable & ~((paddr == `PSQ_OFF_PCL) | (paddr == `PSQ_OFF_TBLP) |
                   (paddr == `PSQ_OFF_TABLE_HIGH_BYTE) | (paddr == `PSQ_OFF_INTEN) | (paddr == `PSQ_OFF_STAT));

  // read mux; only pc low byte is exposed, stack stays hidden
  always @*
  begin
    prdata = 32'h0000_0000;
    case (paddr)
      `PSQ_OFF_PCL: prdata[7:0] = pc_q[7:0];
      `PSQ_OFF_TBLP: prdata[7:0] = tblp_q;
      `PSQ_OFF_TABLE_HIGH_BYTE: prdata[7:0] = table_high_byte_q;
      `PSQ_OFF_INTEN: prdata[5:0] = inten_q;
      `PSQ_OFF_STAT:
      begin
        prdata[4:0] = pend_q;
        prdata[`PSQ_STAT_DUMMY] = (state_q == ST_DUMMY);
        prdata[`PSQ_STAT_TAB] = (state_q == ST_TAB);
      end
      default: prdata = 32'h0000_0000;
    endcase
  end

  // ****************************************
  // interrupt request latching
  // ****************************************
  assign events[`PSQ_IRQ_EXT] = ext_prev_q & ~ext_int_n;
  assign events[`PSQ_IRQ_TM0] = tmr0_ovf;
  assign events[`PSQ_IRQ_TM1] = tmr1_ovf;
  assign events[`PSQ_IRQ_RTC] = rtc_timeout & inten_q[`PSQ_EN_RTCFN];
  assign events[`PSQ_IRQ_MFI] = (pc0_prev_q & ~port_c_bit0) | (pc5_prev_q & ~port_c_bit5) |
                                (~pc7_prev_q & port_c_bit7);
  assign stack_full = (depth_q == STACK_DEPTH[SP_W:0]);
  assign active = pend_q & inten_q[4:0];
  // acknowledge withheld while the stack is full, request stays latched
  assign int_take = (state_q == ST_RUN) & (|active) & ~stack_full & ~pcl_wr;
  assign accept = (state_q == ST_RUN) & instr_valid & ~int_take & ~pcl_wr;

  // pick the highest priority vector
  always @*
  begin
    ack_mask = 5'h00;
    int_vector = `PSQ_VEC_RESET;
    if (active[`PSQ_IRQ_EXT])
    begin
      ack_mask[`PSQ_IRQ_EXT] = 1'b1;
      int_vector = `PSQ_VEC_EXT;
    end
    else if (active[`PSQ_IRQ_TM0])
    begin
      ack_mask[`PSQ_IRQ_TM0] = 1'b1;
      int_vector = `PSQ_VEC_TM0;
    end
    else if (active[`PSQ_IRQ_TM1])
    begin
      ack_mask[`PSQ_IRQ_TM1] = 1'b1;
      int_vector = `PSQ_VEC_TM1;
    end
    else if (active[`PSQ_IRQ_RTC])
    begin
      ack_mask[`PSQ_IRQ_RTC] = 1'b1;
      int_vector = `PSQ_VEC_RTC;
    end
    else if (active[`PSQ_IRQ_MFI])
    begin
      ack_mask[`PSQ_IRQ_MFI] = 1'b1;
      int_vector = `PSQ_VEC_MFI;
    end
    int_ack = int_take;
  end

  // a new event in the acknowledge cycle wins over the clear
  always @*
  begin
    pend_d = (pend_q & ~(int_take ? ack_mask : 5'h00)) | events;
  end

  // ****************************************
  // program counter and stack sequencing
  // ****************************************
  always @*
  begin
    state_d = state_q;
    pc_d = pc_q;
    stack_index_d = stack_index_q;
    depth_d = depth_q;
    push = 1'b0;
    push_val = pc_q;
    if (pcl_wr)
    begin
      pc_d = {pc_q[PC_W-1:8], pwdata[7:0]};
      state_d = ST_DUMMY;
    end
    else if (int_take)
    begin
      push = 1'b1;
      pc_d = int_vector;
      state_d = ST_DUMMY;
    end
    else
    begin
      case (state_q)
        ST_RUN:
        begin
          if (accept)
          begin
            if (op_jump | op_call)
            begin
              pc_d = jump_target;
              state_d = ST_DUMMY;
              if (op_call)
              begin
                push = 1'b1;
                push_val = psq_add(pc_q, 12'h001);
              end
            end
            else if (op_sub_ret | op_int_ret)
            begin
              pc_d = stack_mem[stack_index_q - 3'd1];
              stack_index_d = stack_index_q - 3'd1;
              if (depth_q != 4'h0)
                depth_d = depth_q - 4'h1;
              state_d = ST_DUMMY;
            end
            else if (op_skip)
            begin
              pc_d = psq_add(pc_q, 12'h002);
              state_d = ST_DUMMY;
            end
            else if (op_tab_cur | op_tab_last)
              state_d = ST_TAB;
            else
              pc_d = psq_add(pc_q, 12'h001);
          end
        end
        ST_DUMMY:
          state_d = ST_RUN;
        ST_TAB:
        begin
          pc_d = psq_add(pc_q, 12'h001);
          state_d = ST_RUN;
        end
        default:
          state_d = ST_RUN;
      endcase
    end
    if (push)
    begin
      stack_index_d = stack_index_q + 3'd1; // wraps on overflow
      if (!stack_full)
        depth_d = depth_q + 4'h1;
    end
  end

  // sequencer registers
  always @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      state_q <= ST_RUN;
      pc_q <= `PSQ_VEC_RESET;
      stack_index_q <= 3'd0;
      depth_q <= 4'h0;
      pend_q <= 5'h00;
      ext_prev_q <= 1'b1;
      pc0_prev_q <= 1'b1;
      pc5_prev_q <= 1'b1;
      pc7_prev_q <= 1'b0;
    end
    else
    begin
      state_q <= state_d;
      pc_q <= pc_d;
      stack_index_q <= stack_index_d;
      depth_q <= depth_d;
      pend_q <= pend_d;
      ext_prev_q <= ext_int_n;
      pc0_prev_q <= port_c_bit0;
      pc5_prev_q <= port_c_bit5;
      pc7_prev_q <= port_c_bit7;
    end
  end

  // stack storage, twelve bits per level
  always @(posedge pclk)
  begin
    if (push)
      stack_mem[stack_index_q] <= push_val;
  end

  // ****************************************
  // table read path and software registers
  // ****************************************
  always @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      tblp_q <= `PSQ_RST_TBLP;
      inten_q <= `PSQ_RST_INTEN;
      table_high_byte_q <= 8'h00;
      tab_addr_q <= 12'h000;
      tab_dest_q <= 8'h00;
      tab_wr <= 1'b0;
      tab_low <= 8'h00;
      tab_dest_out <= 8'h00;
    end
    else
    begin
      tab_wr <= 1'b0;
      if (apb_wr && paddr == `PSQ_OFF_TBLP)
        tblp_q <= pwdata[7:0];
      if (apb_wr && paddr == `PSQ_OFF_INTEN)
        inten_q <= pwdata[5:0];
      if (accept && (op_tab_cur | op_tab_last) && !(op_jump | op_call | op_sub_ret | op_int_ret | op_skip))
      begin
        tab_addr_q <= {(op_tab_last ? `PSQ_LAST_PAGE : pc_q[PC_W-1:8]), tblp_q};
        tab_dest_q <= tab_dest;
      end
      if (state_q == ST_TAB && !pcl_wr && !int_take)
      begin
        tab_low <= pm_rdata[7:0];
        tab_dest_out <= tab_dest_q;
        tab_wr <= 1'b1;
        table_high_byte_q <= pm_rdata[15:8];
      end
    end
  end

  // ****************************************
  // outputs
  // ****************************************
  assign pm_addr = (state_q == ST_TAB) ? tab_addr_q : pc_q;
  assign pc = pc_q;
  assign dummy_cycle = (state_q == ST_DUMMY);
  assign core_stall = (state_q != ST_RUN) | int_take | pcl_wr;
  assign table_high_byte = table_high_byte_q;
endmodule // psq_sequencer

// file: tb/psq_chk.sv
// assertions on the program sequencer ports
`timescale 1ns/1ps
module psq_chk #(
  parameter PC_W = 12,
  parameter STACK_DEPTH = 8
) (
  // clock, reset and bus
  input wire pclk,
  input wire presetn,
  input wire psel,
  input wire penable,
  input wire pwrite,
  input wire [11:0] paddr,
  input wire [31:0] pwdata,
  // instruction side
  input wire instr_valid,
  input wire op_skip,
  input wire op_jump,
  input wire op_call,
  input wire op_sub_ret,
  input wire op_int_ret,
  input wire op_tab_cur,
  input wire op_tab_last,
  input wire [PC_W-1:0] jump_target,
  input wire [7:0] tab_dest,
  input wire [15:0] pm_rdata,
  // status
  input wire [PC_W-1:0] pm_addr,
  input wire [PC_W-1:0] pc,
  input wire core_stall,
  input wire dummy_cycle,
  input wire int_ack,
  input wire [PC_W-1:0] int_vector,
  input wire tab_wr,
  input wire [7:0] tab_low,
  input wire [7:0] tab_dest_out,
  input wire [7:0] table_high_byte
);
  // ****
  // helper terms
  // ****
  wire take = instr_valid && !core_stall;
  wire pcl_wr = psel && penable && pwrite && paddr == 12'h000;
  wire ops = op_skip | op_jump | op_call | op_sub_ret | op_int_ret | op_tab_cur | op_tab_last;
  default clocking @(posedge pclk); endclocking
  default disable iff (!presetn);
  pc_reset_a: assert property ($rose(presetn) |-> pc == 12'h000)
    else $error("pc not cleared by reset");
  pc_step_a: assert property (take && !ops && !pcl_wr |=> pc == $past(pc) + 12'h001)
    else $error("pc did not step by one");
  skip_two_a: assert property (take && op_skip |=> dummy_cycle && pc == $past(pc) + 12'h002)
    else $error("skip did not add two with dummy");
  // a low byte write in the dummy cycle legally adds one more dummy cycle
  branch_two_a: assert property (take && (op_jump || op_call) |=>
    dummy_cycle && pc == $past(jump_target) ##1 (!dummy_cycle || $past(pcl_wr)))
    else $error("branch timing or target wrong");
  pcl_page_a: assert property (pcl_wr |=> dummy_cycle && pc[7:0] == 8'($past(pwdata)) &&
    pc[11:8] == 4'($past(pc) >> 8))
    else $error("low byte write jump wrong");
  vec_legal_a: assert property (int_ack |->
    int_vector inside {12'h004, 12'h008, 12'h00c, 12'h014, 12'h018})
    else $error("illegal interrupt vector");
  ack_jump_a: assert property (int_ack |-> core_stall ##1 dummy_cycle && pc == $past(int_vector))
    else $error("acknowledge did not vector");
  tab_last_a: assert property (take && op_tab_last |=>
    core_stall && pm_addr[11:8] == 4'hf ##1 tab_wr)
    else $error("last page read address or timing wrong");
  tab_data_a: assert property (take && op_tab_cur |-> ##2
    tab_low == 8'($past(pm_rdata)) && tab_dest_out == $past(tab_dest, 2) &&
    table_high_byte == 8'($past(pm_rdata) >> 8))
    else $error("table word split wrong");
endmodule // psq_chk
bind psq_sequencer psq_chk #(.PC_W(PC_W), .STACK_DEPTH(STACK_DEPTH)) u_chk (.pclk, .presetn, .psel, .penable,
  .pwrite, .paddr, .pwdata, .instr_valid, .op_skip, .op_jump, .op_call, .op_sub_ret, .op_int_ret, .op_tab_cur,
  .op_tab_last, .jump_target, .tab_dest, .pm_rdata, .pm_addr, .pc, .core_stall, .dummy_cycle, .int_ack,
  .int_vector, .tab_wr, .tab_low, .tab_dest_out, .table_high_byte);

// file: tb/testbench.sv
// self-checking bench for the program sequencer
`timescale 1ns/1ps
module testbench;
  // ****
  // stimulus and observation
  // ****
  reg pclk = 1'h0, presetn = 1'h0, psel = 1'h0, penable = 1'h0, pwrite = 1'h0, instr_valid = 1'h0;
  reg [11:0] paddr = 12'h000, jump_target = 12'h000, adr, vec;
  reg [31:0] pwdata = 32'h0, rd;
  reg [6:0] op = 7'h00, irq = 7'h31;
  reg dmy, se;
  wire [31:0] prdata;
  wire pready, pslverr, core_stall, dummy_cycle, int_ack, tab_wr;
  wire [11:0] pm_addr, pc, int_vector;
  wire [7:0] tab_low, tab_dest_out, table_high_byte;
  wire [15:0] pm_rdata = {pm_addr[7:0] ^ 8'ha5, pm_addr[7:0]};
  integer err_count = 0, comparisons = 0, i, n, acks = 0, a0 = 0;
  // rows: op, target, pc after, dummy, program memory address in the next cycle (table address for table reads)
  localparam [43:0] rows [8] = '{{7'h00, 12'h000, 12'h001, 1'h0, 12'h001}, {7'h02, 12'h123, 12'h123, 1'h1, 12'h123},
    {7'h01, 12'h000, 12'h125, 1'h1, 12'h125}, {7'h04, 12'h300, 12'h300, 1'h1, 12'h300},
    {7'h00, 12'h000, 12'h301, 1'h0, 12'h301}, {7'h08, 12'h000, 12'h126, 1'h1, 12'h126},
    {7'h20, 12'h000, 12'h127, 1'h0, 12'h106}, {7'h40, 12'h000, 12'h128, 1'h0, 12'hf06}};
  localparam [11:0] vtab [7] = '{12'h004, 12'h008, 12'h00c, 12'h014, 12'h018, 12'h018, 12'h018};
  psq_sequencer u_dut (.pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata, .pready, .pslverr,
    .instr_valid, .op_skip(op[0]), .op_jump(op[1]), .op_call(op[2]), .op_sub_ret(op[3]), .op_int_ret(op[4]),
    .op_tab_cur(op[5]), .op_tab_last(op[6]), .jump_target, .tab_dest(8'h5a), .pm_addr, .pm_rdata,
    .ext_int_n(irq[0]), .tmr0_ovf(irq[1]), .tmr1_ovf(irq[2]), .rtc_timeout(irq[3]), .port_c_bit0(irq[4]),
    .port_c_bit5(irq[5]), .port_c_bit7(irq[6]), .pc, .core_stall, .dummy_cycle, .int_ack, .int_vector, .tab_wr,
    .tab_low, .tab_dest_out, .table_high_byte);
  // clock at 40 MHz
  initial forever #12.5 pclk = ~pclk;
  // records each interrupt acknowledge
  always @(negedge pclk)
    if (int_ack === 1'h1)
    begin
      acks = acks + 1;
      vec = int_vector;
    end
  task chk(input logic [31:0] got, input logic [31:0] exp);
    comparisons = comparisons + 1;
    if (got !== exp)
    begin
      err_count = err_count + 1;
      $display("MISMATCH at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  task conclude;
    $display("comparisons %0d, mismatches %0d", comparisons, err_count);
    if (err_count == 0 && comparisons > 0)
      $display("Result: passed");
    else
      $display("Result: failed");
    $finish;
  endtask
  // one cycle of a bounded wait
  task bump;
    n = n + 1;
    if (n > 60)
    begin
      err_count = err_count + 1;
      conclude;
    end
  endtask
  task apb(input logic w, input logic [11:0] a, input logic [31:0] d);
    @(posedge pclk);
    {psel, pwrite, paddr, pwdata} <= {1'h1, w, a, d};
    @(posedge pclk);
    penable <= 1'h1;
    n = 0;
    @(posedge pclk);
    while (pready !== 1'h1)
    begin
      bump;
      @(posedge pclk);
    end
    {rd, se} = {prdata, pslverr};
    {psel, penable} <= 2'h0;
  endtask
  task stall_wait;
    n = 0;
    while (core_stall !== 1'h0)
    begin
      bump;
      @(negedge pclk);
    end
  endtask
  // hold the instruction until an edge with no stall takes it
  task ins(input logic [6:0] o, input logic [11:0] t);
    @(posedge pclk);
    {instr_valid, op, jump_target} <= {1'h1, o, t};
    @(negedge pclk);
    stall_wait;
    @(posedge pclk);
    {instr_valid, op} <= 8'h00;
    @(negedge pclk);
    {dmy, adr} = {dummy_cycle, pm_addr};
    stall_wait;
  endtask
  task pulse(input logic [6:0] m);
    a0 = acks;
    @(posedge pclk);
    irq <= 7'h31 ^ m;
    @(posedge pclk);
    irq <= 7'h31;
  endtask
  task await;
    n = 0;
    while (acks == a0)
    begin
      bump;
      @(negedge pclk);
    end
  endtask
  // ****
  // main sequence
  // ****
  initial
  begin
    repeat (2) @(posedge pclk);
    presetn <= 1'h1;
    @(negedge pclk);
    chk(pc, 12'h000);
    apb(1'h1, 12'h004, 32'h6);
    for (i = 0; i < 8; i = i + 1)
    begin
      ins(rows[i][43:37], rows[i][36:25]);
      chk(pc, rows[i][24:13]);
      chk(dmy, rows[i][12]);
      chk(adr, rows[i][11:0]);
    end
    chk({tab_wr, tab_low, tab_dest_out}, 17'h1065a);
    chk(table_high_byte, 8'ha3);
    apb(1'h1, 12'h008, 32'hff);
    apb(1'h0, 12'h008, 32'h0);
    chk(rd, 32'ha3);
    apb(1'h1, 12'h000, 32'h40);
    @(negedge pclk);
    chk({core_stall, dummy_cycle, pc}, 14'h3140);
    apb(1'h0, 12'h000, 32'h0);
    chk(rd, 32'h40);
    apb(1'h0, 12'h040, 32'h0);
    chk(se, 1'h1);
    apb(1'h1, 12'h00c, 32'h3f);
    for (i = 0; i < 7; i = i + 1)
    begin
      pulse(7'h01 << i);
      await;
      chk(vec, vtab[i]);
      ins(7'h10, 12'h000);
      chk(pc, 12'h140);
    end
    for (i = 0; i < 8; i = i + 1)
      ins(7'h04, 12'h200);
    pulse(7'h02);
    repeat (4) @(negedge pclk);
    chk(acks - a0, 0);
    apb(1'h0, 12'h010, 32'h0);
    chk(rd, 32'h2);
    ins(7'h04, 12'h250);
    chk(pc, 12'h250);
    ins(7'h08, 12'h000);
    await;
    chk(vec, 12'h008);
    @(posedge pclk);
    presetn <= 1'h0;
    repeat (2) @(posedge pclk);
    presetn <= 1'h1;
    @(negedge pclk);
    chk(pc, 12'h000);
    chk({core_stall, dummy_cycle, int_ack, tab_wr}, 4'h0);
    apb(1'h1, 12'h00c, 32'h3f);
    pulse(7'h02);
    await;
    chk(vec, 12'h008);
    ins(7'h10, 12'h000);
    chk(pc, 12'h000);
    conclude;
  end
endmodule // testbench
